// *** rtl/pctrc_pkg.sv ***
// Purpose : Constants for the programmable clock table controller
// Assumes : 10 MHz board clock, byte addresses on the register port
// Notes   : Table defaults live in a function shared by reset logic
package pctrc_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [15:0] PCTRC_PTR_OFS   = 16'h00A0;
   localparam logic [15:0] PCTRC_TAB1_OFS  = 16'h00A4;
   localparam logic [15:0] PCTRC_CTRL_OFS  = 16'h00A8;
   localparam logic [15:0] PCTRC_TAB2_OFS  = 16'h00AC;

   // ==========================================================
   // Control word fields
   localparam int PCTRC_PROG_BIT   = 0;
   localparam int PCTRC_SEL_LSB    = 2;
   localparam int PCTRC_ECHO_BIT   = 6;
   localparam int PCTRC_DIVSET_BIT = 7;
   localparam int PCTRC_DIV_LSB    = 8;
   localparam int PCTRC_DIV_MSB    = 23;

   // ==========================================================
   // Programming span and reset values
   localparam logic [7:0]  PCTRC_FIRST_LOC  = 8'h08;
   localparam logic [7:0]  PCTRC_LAST_LOC   = 8'h57;
   localparam logic [23:0] PCTRC_CTRL_RST   = 24'h000000;
   localparam logic [15:0] PCTRC_DIV_RST    = 16'h0000;
   localparam logic [7:0]  PCTRC_PTR_RST    = 8'h00;

   // ==========================================================
   // Timing: serial bit time and measurement gate
   localparam int PCTRC_CLK_NS     = 100;
   localparam int PCTRC_BIT_NS     = 10000;
   localparam int PCTRC_QUARTER    = PCTRC_BIT_NS / 4 / PCTRC_CLK_NS;
   localparam int PCTRC_GATE_MS    = 100;
   localparam int PCTRC_GATE_CYC   =
      PCTRC_GATE_MS * 1000000 / PCTRC_CLK_NS;

   // Power-up contents of a clock table location
   function automatic logic [7:0] pctrc_tab_default(input int idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx >= 8 && idx <= 13) v = 8'h01;
      case (idx)
         6:  v = 8'hD2;
         7:  v = 8'h08;
         15: v = 8'h50;
         16: v = 8'h55;
         26: v = 8'hE9;
         27: v = 8'h08;
         default: ;
      endcase
      return v;
   endfunction : pctrc_tab_default

endpackage : pctrc_pkg

// *** rtl/pctrc_top.sv ***
// Purpose : Clock table mirror, generator loader, post-dividers, meter
// Assumes : Generator outputs are asynchronous and well below 5 MHz
// Notes   : Both generators share one two-wire bus, chosen by gen_sel_q
`timescale 1ns/1ns

// Function
// R1 - Two separate tables: first for outputs one to three, second for four
// R2 - Pointer register at 0xA0 selects location in both tables
// R3 - Offset 0xA4 reads and writes first table at pointer
// R4 - Offset 0xAC reads and writes second table at pointer
// R5 - Control write starts hardware copy of tables to generators serially
// R6 - Control bit D6 picks measured value or control echo in status
// R7 - Bit D7 set loads post-dividers from D23-D8, else they hold
// R8 - Divider fields four bits per channel from D8; D31-D24 reserved
// R9 - Channel clock divided by two to the field value, up to 32768
// R10 - Status D0 reads zero while programming is in progress
// R11 - Status D1 reads one after a programming error
// R12 - Status D2 reads zero while measuring, one when done
// R13 - Measure the post-divided channel clock chosen by four select bits
// R14 - Result equals one tenth of the measured frequency
// R15 - Software selects channel, clears D6, polls D2 before using result
// R16 - Locations 0x08 to 0x57 map one to one onto generator registers
// R17 - Tables power up with the documented default contents
// R18 - D0 one when idle, D2 one when finished, D7-D3 read zero
// R19 - Control bit D0 starts programming; ignored while already busy
// R20 - Measurement counts selected clock over a fixed reference gate
module pctrc_top
   import pctrc_pkg::*;
#(
   parameter int          GATE_CYCLES = PCTRC_GATE_CYC,
   parameter logic [6:0]  DEV_ADDR    = 7'h2A  // Arbitrary bus address
)
(
   input  wire logic        clock,         // Board clock, 10 MHz
   input  wire logic        nrst,          // Async reset, active low
   input  wire logic        clk_en,        // Freezes all state when low
   input  wire logic [15:0] addr,          // Register byte address
   input  wire logic [31:0] wdata,         // Write data
   input  wire logic        wr,            // Write strobe
   input  wire logic        rd,            // Read strobe
   output logic      [31:0] rdata_q,       // Read data, cycle after rd
   input  wire logic [3:0]  gen_clk,       // Generator outputs one..four
   output logic      [3:0]  chan_clk_q,    // Post-divided channel clocks
   input  wire logic        scl_i,         // Serial clock line level
   output logic             scl_o_q,       // Serial clock drive value
   output logic             scl_oe_q,      // Serial clock drive enable
   input  wire logic        sda_i,         // Serial data line level
   output logic             sda_o_q,       // Serial data drive value
   output logic             sda_oe_q,      // Serial data drive enable
   output logic             gen_sel_q      // 0 first, 1 second generator
);

   typedef enum logic [3:0] {
      PCTRC_IDLE  = 4'b0001,
      PCTRC_START = 4'b0010,
      PCTRC_BIT   = 4'b0100,
      PCTRC_STOP  = 4'b1000
   } pctrc_state_t;

   // ==========================================================
   // Storage and state
   logic [7:0]  first_clock_table  [256];
   logic [7:0]  second_clock_table [256];
   logic [7:0]  ptr_q;
   logic [23:0] ctrl_q;
   logic [15:0] div_q;
   logic        err_q;
   pctrc_state_t st_q;
   logic [1:0]  phase_q;
   logic [7:0]  tick_q;
   logic [3:0]  bit_q;
   logic [1:0]  byte_q;
   logic [7:0]  loc_q;
   logic [3:0]  gen_m_q, gen_s_q, gen_p_q;
   logic [14:0] dcnt_q [4];
   logic        sda_m_q, sda_s_q;
   logic [31:0] gate_q;
   logic [23:0] mcnt_q, result_q;
   logic        mbusy_q, mdone_q, mprev_q;
   logic        busy, tick, sel_valid, mclk;
   logic [1:0]  sel_idx;
   logic [7:0]  tx_byte;
   logic        hit_ptr, hit_t1, hit_t2, hit_ctl;

   assign busy    = (st_q != PCTRC_IDLE);
   assign tick    = (tick_q == 8'(PCTRC_QUARTER - 1));
   assign hit_ptr = (addr == PCTRC_PTR_OFS);
   assign hit_t1  = (addr == PCTRC_TAB1_OFS);
   assign hit_t2  = (addr == PCTRC_TAB2_OFS);
   assign hit_ctl = (addr == PCTRC_CTRL_OFS);

   // ==========================================================
   // Register port
   // Pointer register
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         ptr_q <= PCTRC_PTR_RST;
      else if (clk_en && wr && hit_ptr)
         ptr_q <= wdata[7:0];                             // see R2

   // Clock tables, reset to defaults
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         for (int i = 0; i < 256; i++)
         begin
            first_clock_table[i]  <= pctrc_tab_default(i); // see R17
            second_clock_table[i] <= pctrc_tab_default(i); // see R1
         end
      end
      else if (clk_en && wr)
      begin
         if (hit_t1)
            first_clock_table[ptr_q]  <= wdata[7:0];      // see R3
         if (hit_t2)
            second_clock_table[ptr_q] <= wdata[7:0];      // see R4
      end

   // Stored control word and post-dividers
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         ctrl_q <= PCTRC_CTRL_RST;
         div_q  <= PCTRC_DIV_RST;
      end
      else if (clk_en && wr && hit_ctl)
      begin
         ctrl_q <= wdata[23:0];                           // see R8
         if (wdata[PCTRC_DIVSET_BIT])
            div_q <= wdata[PCTRC_DIV_MSB:PCTRC_DIV_LSB];  // see R7
      end

   // Read data, one cycle after the strobe
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         rdata_q <= 32'h0;
      else if (clk_en)
      begin
         rdata_q <= 32'h0;
         if (rd && hit_ptr)
            rdata_q <= {24'h0, ptr_q};
         else if (rd && hit_t1)
            rdata_q <= {24'h0, first_clock_table[ptr_q]};
         else if (rd && hit_t2)
            rdata_q <= {24'h0, second_clock_table[ptr_q]};
         else if (rd && hit_ctl)
            rdata_q <= {ctrl_q[PCTRC_ECHO_BIT] ? ctrl_q : result_q, // see R6
                        5'h0, mdone_q, err_q, !busy}; // see R10 R12 R18
      end

   // ==========================================================
   // Generator loader
   // Quarter-bit timebase
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         tick_q <= 8'h0;
      else if (clk_en)
         tick_q <= (!busy || tick) ? 8'h0 : tick_q + 8'h1;

   // Serial data line synchroniser
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end
      else if (clk_en)
      begin
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
      end

   // Byte in flight: address, location, table contents
   always_comb
   begin
      unique case (byte_q)
         2'd0:    tx_byte = {DEV_ADDR, 1'b0};
         2'd1:    tx_byte = loc_q;                         // see R16
         default: tx_byte = gen_sel_q ? second_clock_table[loc_q]
                                      : first_clock_table[loc_q];
      endcase
   end

   // Transfer sequencer
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         st_q      <= PCTRC_IDLE;
         phase_q   <= 2'd0;
         bit_q     <= 4'd0;
         byte_q    <= 2'd0;
         loc_q     <= PCTRC_FIRST_LOC;
         gen_sel_q <= 1'b0;
         err_q     <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!busy)
         begin
            if (wr && hit_ctl && wdata[PCTRC_PROG_BIT])   // see R5 R19
            begin
               st_q      <= PCTRC_START;
               phase_q   <= 2'd0;
               loc_q     <= PCTRC_FIRST_LOC;
               gen_sel_q <= 1'b0;
               err_q     <= 1'b0;
            end
         end
         else if (tick)
         begin
            phase_q <= phase_q + 2'd1;
            unique case (st_q)
               PCTRC_START:
                  if (phase_q == 2'd3)
                  begin
                     st_q   <= PCTRC_BIT;
                     bit_q  <= 4'd0;
                     byte_q <= 2'd0;
                  end
               PCTRC_BIT:
               begin
                  if (phase_q == 2'd2 && bit_q == 4'd8 && sda_s_q)
                     err_q <= 1'b1;                        // see R11
                  if (phase_q == 2'd3)
                  begin
                     bit_q <= (bit_q == 4'd8) ? 4'd0 : bit_q + 4'd1;
                     if (bit_q == 4'd8)
                     begin
                        byte_q <= byte_q + 2'd1;
                        if (byte_q == 2'd2)
                           st_q <= PCTRC_STOP;
                     end
                  end
               end
               PCTRC_STOP:
                  if (phase_q == 2'd3)
                  begin
                     st_q <= PCTRC_START;
                     if (loc_q != PCTRC_LAST_LOC)
                        loc_q <= loc_q + 8'h1;             // see R16
                     else if (!gen_sel_q)
                     begin
                        loc_q     <= PCTRC_FIRST_LOC;
                        gen_sel_q <= 1'b1;
                     end
                     else
                        st_q <= PCTRC_IDLE;
                  end
               default:
                  st_q <= PCTRC_IDLE;
            endcase
         end
      end

   // Open-drain line drive: enable pulls the line low
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_o_q  <= 1'b0;
         sda_o_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         unique case (st_q)
            PCTRC_START:
            begin
               scl_oe_q <= (phase_q >= 2'd2);
               sda_oe_q <= (phase_q >= 2'd1);
            end
            PCTRC_BIT:
            begin
               scl_oe_q <= (phase_q == 2'd0) || (phase_q == 2'd3);
               sda_oe_q <= (bit_q != 4'd8) && !tx_byte[3'(7 - bit_q)];
            end
            PCTRC_STOP:
            begin
               scl_oe_q <= (phase_q == 2'd0);
               sda_oe_q <= (phase_q <= 2'd1);
            end
            default:
            begin
               scl_oe_q <= 1'b0;
               sda_oe_q <= 1'b0;
            end
         endcase
      end

   // ==========================================================
   // Channel post-dividers
   // Generator output synchronisers and edge history
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         gen_m_q <= 4'h0;
         gen_s_q <= 4'h0;
         gen_p_q <= 4'h0;
      end
      else if (clk_en)
      begin
         gen_m_q <= gen_clk;
         gen_s_q <= gen_m_q;
         gen_p_q <= gen_s_q;
      end

   // Edge counters and divided outputs
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         chan_clk_q <= 4'h0;
         for (int c = 0; c < 4; c++)
            dcnt_q[c] <= 15'h0;
      end
      else if (clk_en)
      begin
         for (int c = 0; c < 4; c++)
         begin
            if (gen_s_q[c] && !gen_p_q[c])
               dcnt_q[c] <= dcnt_q[c] + 15'h1;
            if (div_q[4*c +: 4] == 4'h0)
               chan_clk_q[c] <= gen_s_q[c];                // see R9
            else
               chan_clk_q[c] <= dcnt_q[c][4'(div_q[4*c +: 4] - 4'h1)];
         end
      end

   // ==========================================================
   // Clock measurement
   // Lowest set select bit picks the channel
   always_comb
   begin
      sel_valid = 1'b1;
      sel_idx   = 2'd0;
      if (ctrl_q[PCTRC_SEL_LSB])          sel_idx = 2'd0;  // see R13
      else if (ctrl_q[PCTRC_SEL_LSB + 1]) sel_idx = 2'd1;
      else if (ctrl_q[PCTRC_SEL_LSB + 2]) sel_idx = 2'd2;
      else if (ctrl_q[PCTRC_SEL_LSB + 3]) sel_idx = 2'd3;
      else                                sel_valid = 1'b0;
   end

   assign mclk = sel_valid && chan_clk_q[sel_idx];

   // Gated edge count, restarted by every control write
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         gate_q   <= 32'h0;
         mcnt_q   <= 24'h0;
         result_q <= 24'h0;
         mbusy_q  <= 1'b0;
         mdone_q  <= 1'b0;
         mprev_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         mprev_q <= mclk;
         if (wr && hit_ctl)
         begin
            gate_q  <= 32'h0;
            mcnt_q  <= 24'h0;
            mprev_q <= 1'b1;       // No false edge on select change
            mbusy_q <= 1'b1;
            mdone_q <= 1'b0;                               // see R12
         end
         else if (mbusy_q)
         begin
            if (mclk && !mprev_q)
               mcnt_q <= mcnt_q + 24'h1;                   // see R20
            gate_q <= gate_q + 32'h1;
            if (gate_q == 32'(GATE_CYCLES - 1))
            begin
               result_q <= mcnt_q + 24'(mclk && !mprev_q); // see R14
               mbusy_q  <= 1'b0;
               mdone_q  <= 1'b1;
            end
         end
      end

   // ==========================================================
   // Checks
   ptr_read_a: assert property (@(posedge clock) disable iff (!nrst) // see R2
      clk_en && rd && hit_ptr |=> !clk_en || rdata_q == {24'h0, $past(ptr_q)})
      else $error("pointer readback wrong");

   prog_start_a: assert property (@(posedge clock) disable iff (!nrst) // see R19
      clk_en && !busy && wr && hit_ctl && wdata[0] |=> !clk_en || busy)
      else $error("programming did not start");

   done_bit_a: assert property (@(posedge clock) disable iff (!nrst) // see R10
      clk_en && rd && hit_ctl |=> !clk_en || rdata_q[0] == !$past(busy))
      else $error("done bit wrong");

   div_load_a: assert property (@(posedge clock) disable iff (!nrst) // see R7
      clk_en && wr && hit_ctl && wdata[7] |=> div_q == $past(wdata[23:8]))
      else $error("post-dividers not loaded");

   div_hold_a: assert property (@(posedge clock) disable iff (!nrst) // see R7
      clk_en && wr && hit_ctl && !wdata[7] |=> $stable(div_q))
      else $error("post-dividers changed");

   echo_read_a: assert property (@(posedge clock) disable iff (!nrst) // see R6
      clk_en && rd && hit_ctl && ctrl_q[6] |=>
         !clk_en || rdata_q[31:8] == $past(ctrl_q))
      else $error("control echo wrong");

   reserved_zero_a: assert property (@(posedge clock) disable iff (!nrst) // see R18
      clk_en && rd && hit_ctl |=> rdata_q[7:3] == 5'h0)
      else $error("reserved status bits set");

   undivided_ch_a: assert property (@(posedge clock) disable iff (!nrst) // see R9
      clk_en && div_q[3:0] == 4'h0 |=>
         !clk_en || chan_clk_q[0] == $past(gen_s_q[0]))
      else $error("undivided channel wrong");

   meas_done_a: assert property (@(posedge clock) disable iff (!nrst) // see R12
      $fell(mbusy_q) |-> mdone_q)
      else $error("measurement end without done");

endmodule : pctrc_top

// *** tb/pctrc_gen_model.sv ***
// Purpose : Behavioural clock generator seen on the two-wire bus
// Assumes : Both lines open drain with pull-ups, resolved in the bench
// Notes   : Records the first three bytes received since reset
`timescale 1ns/1ns
module pctrc_gen_model
(
   input  wire logic        scl,      // Resolved clock line
   input  wire logic        sda,      // Resolved data line
   input  wire logic        nrst,     // Clears bus state
   input  wire logic        nack,     // Refuse every byte
   output logic             sda_oe,   // High pulls data low
   output logic      [23:0] bytes_q,  // First bytes received
   output int               n_bytes   // Bytes received since reset
);
   int         bitc = 0;
   logic [7:0] shreg = 8'h00;

   // ==========================================================
   // Start condition and reset
   initial
   begin
      sda_oe = 1'b0;
      n_bytes = 0;
      bytes_q = 24'h000000;
   end
   always @(negedge sda)
      if (scl === 1'b1)
         bitc = 0;
   always @(negedge nrst)
   begin
      sda_oe = 1'b0;
      bitc = 0;
      n_bytes = 0;
   end

   // ==========================================================
   // Bits taken on rising clock, acknowledge driven while low
   always @(posedge scl)
   begin
      if (bitc < 8)
         shreg = {shreg[6:0], sda};
      bitc = bitc + 1;
   end
   always @(negedge scl)
      if (bitc == 8)
      begin
         sda_oe = !nack;
         if (n_bytes < 3)
            bytes_q = {bytes_q[15:0], shreg};
         n_bytes = n_bytes + 1;
      end
      else if (bitc == 9)
      begin
         sda_oe = 1'b0;
         bitc = 0;
      end
endmodule : pctrc_gen_model

// *** tb/tb_top.sv ***
// Purpose : Self-checking bench for the clock table controller
// Assumes : Gate shortened to 200 cycles, so result is edges in 20 us
// Notes   : Programming runs are cut short by a reset after a few bytes
`timescale 1ns/1ns
module tb_top;
   import pctrc_pkg::*;
   localparam logic [6:0] DEV = 7'h35;  // Arbitrary bus address
   logic        clock = 1'b0;
   logic        nrst, clk_en, wr, rd, nack, model_oe;
   logic [15:0] addr;
   logic [31:0] wdata, rdata_q;
   logic [3:0]  gen_clk = 4'h0;
   logic [3:0]  chan_clk_q;
   logic        scl_o_q, scl_oe_q, sda_o_q, sda_oe_q, gen_sel_q;
   logic [23:0] bytes_q;
   int          n_bytes;
   int          num_errors = 0;
   int          n_tests = 0;
   wire         scl = !scl_oe_q;
   wire         sda = !(sda_oe_q | model_oe);

   // ==========================================================
   // Clocks and instances
   always #50 clock = ~clock;
   always #400 gen_clk[0] = ~gen_clk[0];
   always #500 gen_clk[1] = ~gen_clk[1];
   always #600 gen_clk[2] = ~gen_clk[2];
   always #800 gen_clk[3] = ~gen_clk[3];
   pctrc_top #(.GATE_CYCLES(200), .DEV_ADDR(DEV)) pctrc_top_i
      (.clock(clock), .nrst(nrst), .clk_en(clk_en), .addr(addr),
       .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
       .gen_clk(gen_clk), .chan_clk_q(chan_clk_q), .scl_i(scl),
       .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q), .sda_i(sda),
       .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q), .gen_sel_q(gen_sel_q));
   pctrc_gen_model pctrc_gen_model_i
      (.scl(scl), .sda(sda), .nrst(nrst), .nack(nack),
       .sda_oe(model_oe), .bytes_q(bytes_q), .n_bytes(n_bytes));

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask : wr_reg
   task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata_q;
      @(posedge clock);
   endtask : rd_reg
   task automatic do_reset;
      nrst <= 1'b0;
      repeat (20) @(posedge clock);
      check("idle outputs",
            {scl_o_q, sda_o_q, scl_oe_q, sda_oe_q, gen_sel_q},
            5'h00);
      nrst <= 1'b1;
      @(posedge clock);
   endtask : do_reset
   task automatic wait_bytes(input int n);
      for (int i = 0; i < 5000 && n_bytes < n; i++)
         @(posedge clock);
      check("bytes arrived", n_bytes >= n, 1'b1);
   endtask : wait_bytes

   // ==========================================================
   // Scenarios
   task automatic t_defaults;
      int         loc[6] = '{6, 7, 8, 13, 15, 16};
      logic [7:0] val[6] = '{8'hD2, 8'h08, 8'h01, 8'h01, 8'h50, 8'h55};
      logic [31:0] s;
      rd_reg(PCTRC_PTR_OFS, s);
      check("pointer reset", s, 32'h0);
      rd_reg(PCTRC_CTRL_OFS, s);
      check("idle status", s[7:0] & 8'hFB, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         wr_reg(PCTRC_PTR_OFS, loc[i]);
         rd_reg(PCTRC_TAB1_OFS, s);
         check("table one default", s, val[i]);
         rd_reg(PCTRC_TAB2_OFS, s);
         check("table two default", s, val[i]);
      end
   endtask : t_defaults
   task automatic t_tables;
      logic [31:0] s;
      wr_reg(PCTRC_PTR_OFS, 32'h57);
      wr_reg(PCTRC_TAB1_OFS, 32'hFFFFFFA5);
      wr_reg(PCTRC_TAB2_OFS, 32'h5C);
      wr_reg(16'h00A6, 32'h77);
      rd_reg(PCTRC_TAB1_OFS, s);
      check("table one data", s, 32'hA5);
      rd_reg(PCTRC_TAB2_OFS, s);
      check("table two data", s, 32'h5C);
      wr_reg(PCTRC_PTR_OFS, 32'h13F);
      rd_reg(PCTRC_PTR_OFS, s);
      check("pointer value", s, 32'h3F);
      clk_en <= 1'b0;
      wr_reg(PCTRC_PTR_OFS, 32'h11);
      clk_en <= 1'b1;
      rd_reg(PCTRC_PTR_OFS, s);
      check("frozen pointer", s, 32'h3F);
      rd_reg(PCTRC_TAB1_OFS, s);
      check("table one other", s, 32'h0);
      rd_reg(16'h00B0, s);
      check("unmapped read", s, 32'h0);
   endtask : t_tables
   task automatic t_measure;
      int per[4] = '{800, 1000, 1200, 1600};
      int dv[4] = '{0, 1, 0, 2};
      int e;
      logic [31:0] s;
      wr_reg(PCTRC_CTRL_OFS, 32'h002010C0);
      rd_reg(PCTRC_CTRL_OFS, s);
      check("echo", s & 32'hFFFFFFF8, 32'h2010C000);
      for (int k = 0; k < 4; k++)
      begin
         // Select only, divider bits ignored, readback of result
         wr_reg(PCTRC_CTRL_OFS, 32'hFFFFFF00 | (32'h4 << k));
         rd_reg(PCTRC_CTRL_OFS, s);
         check("meas running", s[2], 1'b0);
         for (int i = 0; i < 300 && s[2] !== 1'b1; i++)
            rd_reg(PCTRC_CTRL_OFS, s);
         check("meas done", s[2], 1'b1);
         e = 20000 / (per[k] << dv[k]);
         check("meas value", s[31:8] >= e - 1 && s[31:8] <= e + 1,
               1'b1);
      end
   endtask : t_measure
   task automatic t_prog_error;
      logic [31:0] s;
      nack <= 1'b1;
      wr_reg(PCTRC_CTRL_OFS, 32'h1);
      rd_reg(PCTRC_CTRL_OFS, s);
      check("prog busy", s[0], 1'b0);
      wait_bytes(2);
      rd_reg(PCTRC_CTRL_OFS, s);
      check("prog error", s[1:0], 2'b10);
      check("first generator", gen_sel_q, 1'b0);
      wr_reg(PCTRC_CTRL_OFS, 32'h1);
      rd_reg(PCTRC_CTRL_OFS, s);
      check("restart ignored", s[1:0], 2'b10);
      nack <= 1'b0;
      do_reset;
      rd_reg(PCTRC_CTRL_OFS, s);
      check("idle again", s[1:0], 2'b01);
   endtask : t_prog_error
   task automatic t_prog_ok;
      logic [31:0] s;
      wr_reg(PCTRC_PTR_OFS, 32'h08);
      wr_reg(PCTRC_TAB1_OFS, 32'h5A);
      wr_reg(PCTRC_CTRL_OFS, 32'h1);
      wait_bytes(3);
      check("serial bytes", bytes_q, {DEV, 1'b0, 16'h085A});
      check("transfer started", n_bytes >= 3, 1'b1);
      rd_reg(PCTRC_CTRL_OFS, s);
      check("prog no error", s[1:0], 2'b00);
      do_reset;
   endtask : t_prog_ok

   // ==========================================================
   // Verdict, watchdog and main sequence
   task automatic end_of_test;
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (40000) @(posedge clock);
      num_errors++;
      end_of_test();
   end
   initial
   begin
      nrst = 1'b0;
      clk_en = 1'b1;
      addr = 16'h0000;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      nack = 1'b0;
      @(posedge clock);
      do_reset;
      t_defaults;
      t_tables;
      t_measure;
      t_prog_error;
      t_prog_ok;
      end_of_test();
   end
endmodule : tb_top
